// file: cbt_bus_model.sv
`timescale 1ns/1ps
// ====================================================================
// Protocol engine and bus stand-in, bit pattern repeats every eight cycles
module cbt_bus_model (
	// Clock and reset
	input wire logic  clk,
	input wire logic  srst,
	// Engine side
	output logic      engine_tx_bit
);
	logic [2:0] cnt_r;
	always_ff @(posedge clk) begin
		cnt_r <= srst ? 3'h0 : cnt_r + 3'h1;
	end
	assign engine_tx_bit = cnt_r[0] ^ cnt_r[2];
endmodule // cbt_bus_model

// file: cbt_core.sv
`timescale 1ns/1ps

// Operation
// - Phase two code n gives n+1 quanta
// - Phase one code n gives n+1 quanta
// - Bit time is prescaler times total quanta
// - Flags clear by write-one once condition gone
// - Interrupt requested when flag and enable set
// - Receive flag bits reset to zero; the status fields follow the engine
// - Error counters cannot be written by software
// - Configuration writes only while init acknowledged
// - Transmit pin recessive in power-down or init
// - Module enable accepts only first write outside special mode
// - Core clock from oscillator or bus clock
module cbt_core
	import cbt_pkg::*;
#(
	parameter int BRP_W = 6
) (
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      srst,
	// Register port
	input  wire logic [cbt_pkg::CBT_ADDR_W-1:0] reg_addr,
	input  wire logic [7:0]                reg_wdata,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	output logic      [7:0]                reg_rdata,
	// System mode and clocks
	input  wire logic                      special_mode,
	input  wire logic                      osc_tick,
	// Protocol engine side
	input  wire cbt_pkg::cbt_status_s      engine_status,
	input  wire logic                      status_change_evt,
	input  wire logic [7:0]                rx_err_count,
	input  wire logic [7:0]                tx_err_count,
	input  wire logic                      engine_tx_bit,
	output logic                           quantum_tick,
	output logic                           sample_tick,
	output logic                           bit_tick,
	output logic                           engine_run,
	// Pins and request
	output logic                           transmit_pin,
	output logic                           irq_req
);

	import cbt_pkg::*;

	// ====================================================================
	// Decoding helpers
	function automatic logic [4:0] seg_quanta(input logic [3:0] code);
		seg_quanta = {1'b0, code} + 5'h01;
	endfunction

	function automatic logic wr_hit(input logic [CBT_ADDR_W-1:0] a,
	                                input logic [CBT_ADDR_W-1:0] off);
		wr_hit = (a == off);
	endfunction

	// ====================================================================
	// State
	cbt_mode_e        mode_r;
	cbt_mode_e        mode_nxt;
	logic [7:0]       ctl0_r;
	logic             enable_r;
	logic             enable_written_r;
	logic             clock_source_select_r;
	logic [5:0]       ctl1_misc_r;
	logic [7:0]       btr0_r;
	logic [7:0]       btr1_r;
	logic [7:0]       idac_r;
	logic [7:0]       acc_code_r [ACC_REGS];
	logic [7:0]       acc_mask_r [ACC_REGS];
	logic [3:0]       flags_r;
	logic [3:0]       flags_nxt;
	logic [7:0]       rier_r;
	logic [BRP_W-1:0] presc_cnt_r;
	logic [4:0]       tq_cnt_r;
	logic             quantum_tick_r;
	logic             sample_tick_r;
	logic             bit_tick_r;
	logic             transmit_pin_r;
	logic [7:0]       rdata_r;

	// ====================================================================
	// Mode control
	wire init_request = ctl0_r[CTL0_INIT_REQUEST];
	wire pdrq   = ctl0_r[CTL0_PDRQ];
	wire in_init = (mode_r == CBT_INIT);
	wire in_pwrdn = (mode_r == CBT_PWRDN);

	always_comb begin
		mode_nxt = mode_r;
		case (mode_r)
			CBT_ONLINE: begin
				if (pdrq)
					mode_nxt = CBT_PWRDN;
				else if (init_request)
					mode_nxt = CBT_INIT;
			end
			CBT_INIT: begin
				if (!init_request)
					mode_nxt = pdrq ? CBT_PWRDN : CBT_ONLINE;
			end
			CBT_PWRDN: begin
				if (!pdrq)
					mode_nxt = init_request ? CBT_INIT : CBT_ONLINE;
			end
			default: mode_nxt = CBT_INIT;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst)
			mode_r <= CBT_ONLINE;
		else
			mode_r <= mode_nxt;
	end

	// ====================================================================
	// Write decode
	wire cfg_open  = in_init;
	wire wr_ctl0   = reg_wr && wr_hit(reg_addr, OFF_CTL0);
	wire wr_ctl1   = reg_wr && wr_hit(reg_addr, OFF_CTL1) && cfg_open;
	wire wr_btr0   = reg_wr && wr_hit(reg_addr, OFF_BTR0) && cfg_open;
	wire wr_btr1   = reg_wr && wr_hit(reg_addr, OFF_BTR1) && cfg_open;
	wire wr_idac   = reg_wr && wr_hit(reg_addr, OFF_IDAC) && cfg_open;
	wire wr_rflg   = reg_wr && wr_hit(reg_addr, OFF_RFLG);
	wire wr_rier   = reg_wr && wr_hit(reg_addr, OFF_RIER);
	wire wr_idar   = reg_wr && (reg_addr[5:3] == OFF_IDAR[5:3]) && cfg_open;
	wire wr_idmr   = reg_wr && (reg_addr[5:3] == OFF_IDMR[5:3]) && cfg_open;
	wire ena_open  = special_mode || !enable_written_r;
	wire ena_wr    = reg_wr && wr_hit(reg_addr, OFF_CTL1) && ena_open;
	// Next enable, so the pin turns recessive on the edge that disables
	wire enable_nxt = ena_wr ? reg_wdata[CTL1_ENA] : enable_r;
	wire [2:0] acc_idx = reg_addr[2:0];

	// ====================================================================
	// Control and configuration registers
	always_ff @(posedge clk) begin
		if (srst) begin
			ctl0_r           <= CTL0_RST;
			enable_r         <= CTL1_RST[CTL1_ENA];
			enable_written_r <= 1'b0;
			clock_source_select_r         <= CTL1_RST[CTL1_CLOCK_SOURCE_SELECT];
			ctl1_misc_r      <= CTL1_RST[5:0];
			btr0_r           <= BTR_RST;
			btr1_r           <= BTR_RST;
			idac_r           <= ACC_RST;
			rier_r           <= RIER_RST;
		end else begin
			if (wr_ctl0)
				ctl0_r <= reg_wdata;
			if (wr_ctl1) begin
				clock_source_select_r    <= reg_wdata[CTL1_CLOCK_SOURCE_SELECT];
				ctl1_misc_r <= {reg_wdata[5:2], 2'b00};
			end
			if (ena_wr) begin
				enable_r         <= reg_wdata[CTL1_ENA];
				enable_written_r <= 1'b1;
			end
			if (wr_btr0)
				btr0_r <= reg_wdata;
			if (wr_btr1)
				btr1_r <= reg_wdata;
			if (wr_idac)
				idac_r <= reg_wdata;
			if (wr_rier)
				rier_r <= reg_wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			for (int i = 0; i < ACC_REGS; i++) begin
				acc_code_r[i] <= ACC_RST;
				acc_mask_r[i] <= ACC_RST;
			end
		end else begin
			if (wr_idar)
				acc_code_r[acc_idx] <= reg_wdata;
			if (wr_idmr)
				acc_mask_r[acc_idx] <= reg_wdata;
		end
	end

	// ====================================================================
	// Receive flags: wakeup, status change, overrun, receive full
	wire [3:0] flag_cond = {engine_status.wakeup, status_change_evt,
	                        engine_status.overrun, engine_status.rx_full};
	wire [3:0] flag_wr1  = wr_rflg ? {reg_wdata[RFLG_WUP], reg_wdata[RFLG_CSC],
	                                  reg_wdata[RFLG_OVR], reg_wdata[RFLG_RXF]}
	                               : 4'h0;
	// Set wins; clear only where the cause has gone
	assign flags_nxt = (flags_r & ~(flag_wr1 & ~flag_cond)) | flag_cond;

	always_ff @(posedge clk) begin
		if (srst)
			flags_r <= RFLG_RST[3:0];
		else
			flags_r <= flags_nxt;
	end

	wire [7:0] rflg_view;
	assign rflg_view[RFLG_WUP] = flags_r[3];
	assign rflg_view[RFLG_CSC] = flags_r[2];
	assign rflg_view[RFLG_RST_LSB+1:RFLG_RST_LSB] = engine_status.rx_state;
	assign rflg_view[RFLG_TST_LSB+1:RFLG_TST_LSB] = engine_status.tx_state;
	assign rflg_view[RFLG_OVR] = flags_r[1];
	assign rflg_view[RFLG_RXF] = flags_r[0];

	wire [7:0] rier_mask = {rier_r[RFLG_WUP], rier_r[RFLG_CSC], 4'h0,
	                        rier_r[RFLG_OVR], rier_r[RFLG_RXF]};
	assign irq_req = |(rflg_view & rier_mask);

	// ====================================================================
	// Bit timing
	wire [BRP_W-1:0] brp     = btr0_r[BRP_W-1:0];
	wire [4:0]       ts1_tq  = seg_quanta(btr1_r[BTR1_TS1_MSB:0]);
	wire [4:0]       ts2_tq  = seg_quanta({1'b0, btr1_r[BTR1_TS2_LSB+2:BTR1_TS2_LSB]});
	wire [4:0]       bit_len = 5'h01 + ts1_tq + ts2_tq;
	wire             timing_bad = (ts1_tq < TS1_MIN_TQ) || (ts2_tq < TS2_MIN_TQ);
	wire             can_tick = clock_source_select_r ? 1'b1 : osc_tick;
	wire             run      = enable_r && (mode_r == CBT_ONLINE);
	wire             tq_end   = run && can_tick && (presc_cnt_r == brp);
	wire             bit_end  = tq_end && (tq_cnt_r == bit_len - 5'h01);

	always_ff @(posedge clk) begin
		if (srst) begin
			presc_cnt_r    <= '0;
			tq_cnt_r       <= 5'h00;
			quantum_tick_r <= 1'b0;
			sample_tick_r  <= 1'b0;
			bit_tick_r     <= 1'b0;
		end else begin
			quantum_tick_r <= tq_end;
			sample_tick_r  <= tq_end && (tq_cnt_r == ts1_tq);
			bit_tick_r     <= bit_end;
			if (!run) begin
				presc_cnt_r <= '0;
				tq_cnt_r    <= 5'h00;
			end else begin
				if (can_tick)
					presc_cnt_r <= tq_end ? '0 : presc_cnt_r + 1'b1;
				if (tq_end)
					tq_cnt_r <= bit_end ? 5'h00 : tq_cnt_r + 5'h01;
			end
		end
	end

	assign quantum_tick = quantum_tick_r;
	assign sample_tick  = sample_tick_r;
	assign bit_tick     = bit_tick_r;
	assign engine_run   = run;

	// ====================================================================
	// Transmit pin
	wire force_recessive = (mode_nxt != CBT_ONLINE) || !enable_nxt;

	always_ff @(posedge clk) begin
		if (srst)
			transmit_pin_r <= 1'b1;
		else
			transmit_pin_r <= force_recessive ? 1'b1 : engine_tx_bit;
	end

	assign transmit_pin = transmit_pin_r;

	// ====================================================================
	// Read path
	wire [7:0] ctl1_view = {enable_r, clock_source_select_r, ctl1_misc_r[5:2], in_pwrdn, in_init};
	wire [7:0] bitlen_view = {timing_bad, 2'b00, bit_len};
	logic [7:0] rd_mux;

	always_comb begin
		rd_mux = 8'h00;
		if (reg_addr[5:3] == OFF_IDAR[5:3])
			rd_mux = acc_code_r[acc_idx];
		else if (reg_addr[5:3] == OFF_IDMR[5:3])
			rd_mux = acc_mask_r[acc_idx];
		else begin
			case (reg_addr)
				OFF_CTL0:   rd_mux = ctl0_r;
				OFF_CTL1:   rd_mux = ctl1_view;
				OFF_BTR0:   rd_mux = btr0_r;
				OFF_BTR1:   rd_mux = btr1_r;
				OFF_RFLG:   rd_mux = rflg_view;
				OFF_RIER:   rd_mux = rier_r;
				OFF_IDAC:   rd_mux = idac_r;
				OFF_RXERR:  rd_mux = rx_err_count;
				OFF_TXERR:  rd_mux = tx_err_count;
				OFF_BITLEN: rd_mux = bitlen_view;
				default:    rd_mux = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst)
			rdata_r <= 8'h00;
		else
			rdata_r <= reg_rd ? rd_mux : 8'h00;
	end

	assign reg_rdata = rdata_r;

endmodule // cbt_core

// file: cbt_core_assertions.sv
`timescale 1ns/1ps
// ====================================================================
// Port checker
module cbt_checker
	import cbt_pkg::*;
(
	// Clock and reset
	input wire logic                            clk,
	input wire logic                            srst,
	// Register port
	input wire logic [cbt_pkg::CBT_ADDR_W-1:0] reg_addr,
	input wire logic                            reg_rd,
	input wire logic [7:0]                      reg_rdata,
	// Engine side
	input wire cbt_pkg::cbt_status_s            engine_status,
	input wire logic [7:0]                      rx_err_count,
	input wire logic [7:0]                      tx_err_count,
	input wire logic                            engine_tx_bit,
	input wire logic                            quantum_tick,
	input wire logic                            sample_tick,
	input wire logic                            bit_tick,
	input wire logic                            engine_run,
	input wire logic                            transmit_pin
);
	import cbt_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside its slot");
	rx_err_a: assert property ($past(reg_rd && reg_addr == OFF_RXERR) |->
		reg_rdata == $past(rx_err_count)) else $error("rx count read wrong");
	tx_err_a: assert property ($past(reg_rd && reg_addr == OFF_TXERR) |->
		reg_rdata == $past(tx_err_count)) else $error("tx count read wrong");
	status_live_a: assert property ($past(reg_rd && reg_addr == OFF_RFLG) |->
		reg_rdata[5:2] == $past({engine_status.rx_state, engine_status.tx_state}))
		else $error("status fields wrong");
	tx_recessive_a: assert property (!engine_run |-> transmit_pin)
		else $error("pin not recessive");
	tx_follow_a: assert property (engine_run |-> transmit_pin == $past(engine_tx_bit))
		else $error("pin not following engine");
	tick_align_a: assert property (bit_tick |-> quantum_tick)
		else $error("bit end off quantum end");
	tick_idle_a: assert property (!$past(engine_run) && !$past(engine_run, 2) |->
		!quantum_tick) else $error("quantum while stopped");
	sample_point_a: assert property (sample_tick |-> quantum_tick && !bit_tick)
		else $error("sample point off quantum or at bit end");
	cover property (bit_tick);
	cover property (sample_tick);
	cover property (!engine_run ##1 engine_run);
	cover property (engine_run ##1 !engine_run);
endmodule // cbt_checker

bind cbt_core cbt_checker chk_i (.clk(clk), .srst(srst), .reg_addr(reg_addr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .engine_status(engine_status),
	.rx_err_count(rx_err_count), .tx_err_count(tx_err_count),
	.engine_tx_bit(engine_tx_bit), .quantum_tick(quantum_tick),
	.sample_tick(sample_tick), .bit_tick(bit_tick),
	.engine_run(engine_run), .transmit_pin(transmit_pin));

// file: cbt_pkg.sv
package cbt_pkg;

	// ====================================================================
	// Register offsets
	localparam int          CBT_ADDR_W   = 6;
	localparam logic [5:0]  OFF_CTL0     = 6'h00;
	localparam logic [5:0]  OFF_CTL1     = 6'h01;
	localparam logic [5:0]  OFF_BTR0     = 6'h02;
	localparam logic [5:0]  OFF_BTR1     = 6'h03;
	localparam logic [5:0]  OFF_RFLG     = 6'h04;
	localparam logic [5:0]  OFF_RIER     = 6'h05;
	localparam logic [5:0]  OFF_IDAC     = 6'h06;
	localparam logic [5:0]  OFF_RXERR    = 6'h07;
	localparam logic [5:0]  OFF_TXERR    = 6'h08;
	localparam logic [5:0]  OFF_BITLEN   = 6'h09;
	localparam logic [5:0]  OFF_IDAR     = 6'h10;
	localparam logic [5:0]  OFF_IDMR     = 6'h18;
	localparam int          ACC_REGS     = 8;

	// ====================================================================
	// Field positions
	localparam int          CTL0_INIT_REQUEST  = 0;
	localparam int          CTL0_PDRQ    = 1;
	localparam int          CTL1_INIT_ACKNOWLEDGE  = 0;
	localparam int          CTL1_PDAK    = 1;
	localparam int          CTL1_CLOCK_SOURCE_SELECT  = 6;
	localparam int          CTL1_ENA     = 7;
	localparam int          RFLG_WUP     = 7;
	localparam int          RFLG_CSC     = 6;
	localparam int          RFLG_RST_LSB = 4;
	localparam int          RFLG_TST_LSB = 2;
	localparam int          RFLG_OVR     = 1;
	localparam int          RFLG_RXF     = 0;
	localparam int          BTR0_BRP_MSB = 5;
	localparam int          BTR1_TS2_LSB = 4;
	localparam int          BTR1_TS1_MSB = 3;
	localparam int          BITLEN_BAD   = 7;

	// ====================================================================
	// Reset values and limits
	localparam logic [7:0]  CTL0_RST     = 8'h01;
	localparam logic [7:0]  CTL1_RST     = 8'h00;
	localparam logic [7:0]  BTR_RST      = 8'h00;
	localparam logic [7:0]  RFLG_RST     = 8'h00;
	localparam logic [7:0]  RIER_RST     = 8'h00;
	localparam logic [7:0]  ACC_RST      = 8'h00;
	localparam logic [4:0]  TS1_MIN_TQ   = 5'h04;
	localparam logic [4:0]  TS2_MIN_TQ   = 5'h02;

	// ====================================================================
	// Types
	typedef enum logic [1:0] {CBT_ONLINE, CBT_INIT, CBT_PWRDN} cbt_mode_e;

	typedef struct packed {
		logic       wakeup;
		logic       overrun;
		logic       rx_full;
		logic [1:0] rx_state;
		logic [1:0] tx_state;
	} cbt_status_s;

endpackage

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
	import cbt_pkg::*;
	logic clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, special_mode = 0, osc_tick = 0, evt = 0;
	logic [5:0] reg_addr = 6'h00;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, d;
	cbt_status_s st = '0;
	logic q_t, s_t, b_t, run, pin, irq, etx;
	logic [7:0] bt[3] = '{8'h00, 8'h7F, 8'h13};
	logic [7:0] bl[3] = '{8'h83, 8'h19, 8'h07};
	int err_count = 0, num_checks = 0, cyc = 0;
	always #12.5 clk = ~clk;
	always @(posedge clk) osc_tick <= ~osc_tick;
	cbt_core dut (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .special_mode(special_mode),
		.osc_tick(osc_tick), .engine_status(st), .status_change_evt(evt),
		.rx_err_count(8'h3C), .tx_err_count(8'hC3), .engine_tx_bit(etx),
		.quantum_tick(q_t), .sample_tick(s_t), .bit_tick(b_t), .engine_run(run),
		.transmit_pin(pin), .irq_req(irq));
	cbt_bus_model bus (.clk(clk), .srst(srst), .engine_tx_bit(etx));
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	task wr(input logic [5:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 0;
	endtask
	task rd(input logic [5:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 0;
		#1 chk("reg", e, reg_rdata);
	endtask
	task meas(input logic [7:0] e);
		int n;
		for (int k = 0; k < 2; k++) begin
			n = 0;
			do begin @(posedge clk); #1 n++; end while (b_t !== 1'b1 && n < 300);
		end
		chk("bit_len", e, n[7:0]);
	endtask
	task results;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			results;
		end
	end
	initial begin
		repeat (6) @(posedge clk);
		srst <= 0;
		rd(OFF_RFLG, 8'h00);
		rd(OFF_CTL1, 8'h01);
		wr(OFF_CTL1, 8'h80);
		wr(OFF_BTR0, 8'h01);
		for (int i = 0; i < 3; i++) begin
			wr(OFF_BTR1, bt[i]);
			rd(OFF_BITLEN, bl[i]);
		end
		wr(OFF_IDAR + 6'h03, 8'hA5);
		wr(OFF_CTL0, 8'h00);
		rd(OFF_CTL1, 8'h80);
		wr(OFF_BTR1, 8'h77);
		rd(OFF_BTR1, 8'h13);
		wr(OFF_IDAR + 6'h03, 8'h5A);
		rd(OFF_IDAR + 6'h03, 8'hA5);
		wr(OFF_CTL1, 8'h00);
		rd(OFF_CTL1, 8'h80);
		wr(OFF_RXERR, 8'h55);
		rd(OFF_RXERR, 8'h3C);
		meas(8'd28);
		@(posedge clk);
		st <= '{1'b1, 1'b1, 1'b1, 2'b10, 2'b00};
		evt <= 1;
		@(posedge clk);
		evt <= 0;
		st.wakeup <= 0;
		st.overrun <= 0;
		wr(OFF_RFLG, 8'h01);
		rd(OFF_RFLG, 8'hE3);
		st.rx_full <= 0;
		wr(OFF_RFLG, 8'h01);
		rd(OFF_RFLG, 8'hE2);
		wr(OFF_RIER, 8'h02);
		#1 chk("irq", 8'h01, {7'h00, irq});
		wr(OFF_RIER, 8'h01);
		#1 chk("irq", 8'h00, {7'h00, irq});
		wr(OFF_RFLG, 8'hC2);
		rd(OFF_RFLG, 8'h20);
		wr(OFF_CTL0, 8'h02);
		repeat (2) @(posedge clk);
		#1 chk("pin", 8'h01, {7'h00, pin});
		rd(OFF_CTL1, 8'h82);
		wr(OFF_CTL0, 8'h01);
		rd(OFF_CTL1, 8'h81);
		wr(OFF_CTL1, 8'h40);
		rd(OFF_CTL1, 8'hC1);
		special_mode <= 1;
		wr(OFF_CTL1, 8'h40);
		rd(OFF_CTL1, 8'h41);
		wr(OFF_CTL1, 8'hC0);
		wr(OFF_CTL0, 8'h00);
		meas(8'd14);
		results;
	end
endmodule // testbench
